/* memory_order_consts.svh */
// Named offsets, field positions and timing counts for the memory ordering block
`ifndef MEMORY_ORDER_CONSTS_SVH
`define MEMORY_ORDER_CONSTS_SVH
`define PHYS_ADDR_WIDTH 44
`define IO_SPACE_BIT 43
`define BLOCK_OFFSET_BITS 6
`define QUAD_OFFSET_BITS 3
`define BYTE_MASK_WIDTH 8
`define LINE_INDEX_BITS 9
`define PC_WIDTH 48
`define PC_INDEX_LSB 2
`define WAIT_TABLE_ENTRIES 1024
`define SHORT_CLEAR_CYCLES 16384
`define LONG_CLEAR_CYCLES 65536
`define CLEAR_COUNT_WIDTH 17
`endif

/* memory_order_pkg.sv */
// Types shared by the memory ordering and replay control block
package memory_order_pkg;
	typedef enum logic [2:0] {
		load_op = 3'h0,
		store_op = 3'h1,
		store_conditional_op = 3'h2,
		write_hint_block_op = 3'h3,
		evict_block_op = 3'h4,
		istream_fetch_op = 3'h5
	} miss_kind_type;
	typedef enum logic [3:0] {
		trap_none = 4'h0,
		trap_load_load = 4'h1,
		trap_store_load = 4'h2,
		trap_queue_full = 4'h4,
		trap_line_conflict = 4'h8
	} trap_kind_type;
endpackage

/* store_wait_predictor.sv */
// One-bit store wait table indexed by program counter, with periodic clearing
`timescale 1ns/1ps
`include "memory_order_consts.svh"
module store_wait_predictor #(
	parameter int ENTRIES = `WAIT_TABLE_ENTRIES,
	parameter int SHORT_CLEAR = `SHORT_CLEAR_CYCLES,
	parameter int LONG_CLEAR = `LONG_CLEAR_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [$clog2(ENTRIES)-1:0] fetch_index,
	output logic fetch_wait_bit,
	input wire logic set_valid,
	input wire logic [$clog2(ENTRIES)-1:0] set_index,
	input wire logic long_clear_interval_select
);
	localparam int IW = $clog2(ENTRIES);
	initial begin
		if (ENTRIES < 2 || (1 << IW) != ENTRIES || SHORT_CLEAR < 1 || LONG_CLEAR < 1
			|| LONG_CLEAR >= (1 << `CLEAR_COUNT_WIDTH))
			$error("store_wait_predictor: unsupported parameters");
	end
	logic [ENTRIES-1:0] table_bits;
	logic [`CLEAR_COUNT_WIDTH-1:0] clear_count;
	wire logic [`CLEAR_COUNT_WIDTH-1:0] clear_limit = long_clear_interval_select ?
		`CLEAR_COUNT_WIDTH'(LONG_CLEAR - 1) : `CLEAR_COUNT_WIDTH'(SHORT_CLEAR - 1);
	wire logic clear_all = clear_count >= clear_limit;
	////////////////////////////////////////////////////////////////////////////////
	// Interval counter; every entry not being set that cycle is wiped when it expires
	always_ff @(posedge clock) begin
		if (reset || clear_all) begin
			clear_count <= '0;
		end else begin
			clear_count <= clear_count + 1'b1;
		end
	end
	// Table storage; a set in the wipe cycle survives the wipe
	genvar i;
	generate
		for (i = 0; i < ENTRIES; i++) begin : g_bit
			always_ff @(posedge clock) begin
				if (reset) begin
					table_bits[i] <= 1'b0;
				end else if (set_valid && set_index == IW'(i)) begin
					table_bits[i] <= 1'b1;
				end else if (clear_all) begin
					table_bits[i] <= 1'b0;
				end
			end
		end
	endgenerate
	// Bit read out with each fetched instruction
	always_ff @(posedge clock) begin
		if (reset) begin
			fetch_wait_bit <= 1'b0;
		end else begin
			fetch_wait_bit <= table_bits[fetch_index];
		end
	end
endmodule

/* memory_order_replay_control.sv */
// Miss merging, load queue order checks, replay trap selection and store wait table
`timescale 1ns/1ps
`include "memory_order_consts.svh"
module memory_order_replay_control
	import memory_order_pkg::*;
#(
	parameter int LQ_DEPTH = 8,
	parameter int MAF_DEPTH = 8,
	parameter int AGE_WIDTH = 7,
	parameter int SHORT_CLEAR = `SHORT_CLEAR_CYCLES,
	parameter int LONG_CLEAR = `LONG_CLEAR_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic full_memory_barrier,
	input wire logic write_memory_barrier,
	output logic hold_load_issue,
	output logic hold_store_issue,
	input wire logic load_issue_valid,
	input wire logic [`PHYS_ADDR_WIDTH-1:0] load_issue_addr,
	input wire logic [`BYTE_MASK_WIDTH-1:0] load_issue_mask,
	input wire logic [AGE_WIDTH-1:0] load_issue_age,
	input wire logic [`PC_WIDTH-1:0] load_issue_pc,
	input wire logic store_issue_valid,
	input wire logic [`PHYS_ADDR_WIDTH-1:0] store_issue_addr,
	input wire logic [`BYTE_MASK_WIDTH-1:0] store_issue_mask,
	input wire logic [AGE_WIDTH-1:0] store_issue_age,
	input wire logic [`PC_WIDTH-1:0] store_issue_pc,
	input wire logic retire_valid,
	input wire logic [AGE_WIDTH-1:0] retire_age,
	input wire logic miss_valid,
	input wire memory_order_pkg::miss_kind_type miss_kind,
	input wire logic [`PHYS_ADDR_WIDTH-1:0] miss_addr,
	input wire logic [AGE_WIDTH-1:0] miss_age,
	input wire logic [`PC_WIDTH-1:0] miss_pc,
	input wire logic fill_valid,
	input wire logic [$clog2(MAF_DEPTH)-1:0] fill_entry,
	output logic miss_merged,
	output logic miss_allocated,
	output logic [$clog2(MAF_DEPTH)-1:0] miss_entry,
	output logic replay_valid,
	output memory_order_pkg::trap_kind_type replay_kind,
	output logic [AGE_WIDTH-1:0] replay_age,
	output logic [`PC_WIDTH-1:0] replay_pc,
	input wire logic [`PC_WIDTH-1:0] virtual_program_counter,
	input wire logic long_clear_interval_select,
	output logic store_wait_bit
);
	localparam int MW = $clog2(MAF_DEPTH);
	localparam int BA = `PHYS_ADDR_WIDTH - `BLOCK_OFFSET_BITS;
	localparam int QA = `PHYS_ADDR_WIDTH - `QUAD_OFFSET_BITS;
	localparam int WI = $clog2(`WAIT_TABLE_ENTRIES);
	initial begin
		if (LQ_DEPTH < 1 || MAF_DEPTH < 2 || (1 << MW) != MAF_DEPTH || AGE_WIDTH < 2)
			$error("memory_order_replay_control: unsupported parameters");
	end
	////////////////////////////////////////////////////////////////////////////////
	// Age compare: true when a lies after b in program order
	function automatic logic is_newer(input logic [AGE_WIDTH-1:0] a, input logic [AGE_WIDTH-1:0] b);
		logic [AGE_WIDTH-1:0] d;
		d = a - b;
		return d != '0 && !d[AGE_WIDTH-1];
	endfunction
	// Merge table: like kinds merge, and a new load joins a store entry
	function automatic logic may_merge(input miss_kind_type held, input miss_kind_type fresh);
		return held == fresh || (held == store_op && fresh == load_op);
	endfunction
	// Byte overlap within one quadword
	function automatic logic bytes_overlap(input logic [QA-1:0] qa, input logic [`BYTE_MASK_WIDTH-1:0] ma,
		input logic [QA-1:0] qb, input logic [`BYTE_MASK_WIDTH-1:0] mb);
		return qa == qb && (ma & mb) != '0;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Load queue state
	logic [LQ_DEPTH-1:0] lq_valid;
	logic [LQ_DEPTH-1:0] lq_io;
	logic [QA-1:0] lq_quad [LQ_DEPTH];
	logic [`BYTE_MASK_WIDTH-1:0] lq_mask [LQ_DEPTH];
	logic [AGE_WIDTH-1:0] lq_age [LQ_DEPTH];
	logic [`PC_WIDTH-1:0] lq_pc [LQ_DEPTH];
	wire logic load_io = load_issue_addr[`IO_SPACE_BIT];
	wire logic store_io = store_issue_addr[`IO_SPACE_BIT];
	wire logic [QA-1:0] load_quad = load_issue_addr[`PHYS_ADDR_WIDTH-1:`QUAD_OFFSET_BITS];
	wire logic [QA-1:0] store_quad = store_issue_addr[`PHYS_ADDR_WIDTH-1:`QUAD_OFFSET_BITS];
	// Barriers override the default order by holding issue
	assign hold_load_issue = full_memory_barrier;
	assign hold_store_issue = full_memory_barrier || write_memory_barrier;
	// Per-entry order hits: same bytes for memory, any address among I/O loads
	logic [LQ_DEPTH-1:0] ll_hit;
	logic [LQ_DEPTH-1:0] sl_hit;
	genvar g;
	generate
		for (g = 0; g < LQ_DEPTH; g++) begin : g_cmp
			assign ll_hit[g] = load_issue_valid && lq_valid[g] && is_newer(lq_age[g], load_issue_age)
				&& (bytes_overlap(lq_quad[g], lq_mask[g], load_quad, load_issue_mask)
				|| (load_io && lq_io[g]));
			assign sl_hit[g] = store_issue_valid && lq_valid[g] && is_newer(lq_age[g], store_issue_age)
				&& lq_io[g] == store_io
				&& bytes_overlap(lq_quad[g], lq_mask[g], store_quad, store_issue_mask);
		end
	endgenerate
	// Oldest hit in the queue becomes the order trap target
	logic order_hit;
	logic order_store_load;
	logic [AGE_WIDTH-1:0] order_age;
	logic [`PC_WIDTH-1:0] order_pc;
	always_comb begin
		order_hit = 1'b0;
		order_store_load = 1'b0;
		order_age = '0;
		order_pc = '0;
		for (int k = 0; k < LQ_DEPTH; k++) begin
			if ((ll_hit[k] || sl_hit[k]) && (!order_hit || is_newer(order_age, lq_age[k]))) begin
				order_hit = 1'b1;
				order_store_load = sl_hit[k];
				order_age = lq_age[k];
				order_pc = lq_pc[k];
			end
		end
	end
	// Free slot for an incoming load; none means a flow trap on that load
	logic lq_has_free;
	logic [$clog2(LQ_DEPTH+1)-1:0] lq_free_slot;
	always_comb begin
		lq_has_free = 1'b0;
		lq_free_slot = '0;
		for (int k = LQ_DEPTH - 1; k >= 0; k--) begin
			if (!lq_valid[k]) begin
				lq_has_free = 1'b1;
				lq_free_slot = ($clog2(LQ_DEPTH+1))'(k);
			end
		end
	end
	wire logic lq_full_trap = load_issue_valid && !lq_has_free;
	////////////////////////////////////////////////////////////////////////////////
	// Miss address file state and lookup
	logic [MAF_DEPTH-1:0] maf_valid;
	logic [BA-1:0] maf_block [MAF_DEPTH];
	miss_kind_type maf_kind [MAF_DEPTH];
	wire logic [BA-1:0] miss_block = miss_addr[`PHYS_ADDR_WIDTH-1:`BLOCK_OFFSET_BITS];
	logic [MAF_DEPTH-1:0] maf_same_block;
	logic [MAF_DEPTH-1:0] maf_mergeable;
	logic [MAF_DEPTH-1:0] maf_line_clash;
	generate
		for (g = 0; g < MAF_DEPTH; g++) begin : g_maf
			assign maf_same_block[g] = maf_valid[g] && maf_block[g] == miss_block;
			assign maf_mergeable[g] = maf_same_block[g] && may_merge(maf_kind[g], miss_kind);
			assign maf_line_clash[g] = maf_valid[g] && !maf_same_block[g]
				&& maf_block[g][`LINE_INDEX_BITS-1:0] == miss_block[`LINE_INDEX_BITS-1:0];
		end
	endgenerate
	// Lowest matching entry and lowest free entry
	logic [MW-1:0] merge_index;
	logic [MW-1:0] free_index;
	logic maf_has_free;
	always_comb begin
		merge_index = '0;
		free_index = '0;
		maf_has_free = 1'b0;
		for (int k = MAF_DEPTH - 1; k >= 0; k--) begin
			if (maf_mergeable[k]) begin
				merge_index = MW'(k);
			end
			if (!maf_valid[k]) begin
				maf_has_free = 1'b1;
				free_index = MW'(k);
			end
		end
	end
	wire logic do_merge = miss_valid && |maf_mergeable;
	wire logic miss_trap = miss_valid && !do_merge && (|maf_line_clash || !maf_has_free);
	wire logic do_alloc = miss_valid && !do_merge && !miss_trap;
	////////////////////////////////////////////////////////////////////////////////
	// Trap arbitration: oldest target among order, flow and line conflict traps
	logic next_valid;
	trap_kind_type next_kind;
	logic [AGE_WIDTH-1:0] next_age;
	logic [`PC_WIDTH-1:0] next_pc;
	always_comb begin
		next_valid = order_hit;
		next_kind = order_store_load ? trap_store_load : trap_load_load;
		next_age = order_age;
		next_pc = order_pc;
		if (lq_full_trap && (!next_valid || is_newer(next_age, load_issue_age))) begin
			next_valid = 1'b1;
			next_kind = trap_queue_full;
			next_age = load_issue_age;
			next_pc = load_issue_pc;
		end
		if (miss_trap && (!next_valid || is_newer(next_age, miss_age))) begin
			next_valid = 1'b1;
			next_kind = |maf_line_clash ? trap_line_conflict : trap_queue_full;
			next_age = miss_age;
			next_pc = miss_pc;
		end
		if (!next_valid) begin
			next_kind = trap_none;
		end
	end
	// Replay outputs and miss answers, one-cycle pulses
	always_ff @(posedge clock) begin
		if (reset) begin
			replay_valid <= 1'b0;
			replay_kind <= trap_none;
			replay_age <= '0;
			replay_pc <= '0;
			miss_merged <= 1'b0;
			miss_allocated <= 1'b0;
			miss_entry <= '0;
		end else begin
			replay_valid <= next_valid;
			replay_kind <= next_kind;
			replay_age <= next_age;
			replay_pc <= next_pc;
			miss_merged <= do_merge;
			miss_allocated <= do_alloc;
			miss_entry <= do_merge ? merge_index : free_index;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Load queue update: fill, retire, and flush of the trap target and newer
	generate
		for (g = 0; g < LQ_DEPTH; g++) begin : g_lq
			wire logic flush = next_valid && !is_newer(next_age, lq_age[g]);
			wire logic take = load_issue_valid && lq_has_free && lq_free_slot == ($clog2(LQ_DEPTH+1))'(g)
				&& !(next_valid && !is_newer(next_age, load_issue_age));
			always_ff @(posedge clock) begin
				if (reset) begin
					lq_valid[g] <= 1'b0;
				end else if (take) begin
					lq_valid[g] <= 1'b1;
				end else if (flush || (retire_valid && lq_age[g] == retire_age)) begin
					lq_valid[g] <= 1'b0;
				end
			end
			always_ff @(posedge clock) begin
				if (take) begin
					lq_io[g] <= load_io;
					lq_quad[g] <= load_quad;
					lq_mask[g] <= load_issue_mask;
					lq_age[g] <= load_issue_age;
					lq_pc[g] <= load_issue_pc;
				end
			end
		end
	endgenerate
	// Miss address file update: allocate and free on fill
	generate
		for (g = 0; g < MAF_DEPTH; g++) begin : g_maf_upd
			always_ff @(posedge clock) begin
				if (reset) begin
					maf_valid[g] <= 1'b0;
				end else if (do_alloc && free_index == MW'(g)) begin
					maf_valid[g] <= 1'b1;
				end else if (fill_valid && fill_entry == MW'(g)) begin
					maf_valid[g] <= 1'b0;
				end
			end
			always_ff @(posedge clock) begin
				if (do_alloc && free_index == MW'(g)) begin
					maf_block[g] <= miss_block;
					maf_kind[g] <= miss_kind;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////////
	// Store wait table; marked on the refetch cycle of a store-load trap
	wire logic wait_set = replay_valid && replay_kind == trap_store_load;
	store_wait_predictor #(
		.ENTRIES(`WAIT_TABLE_ENTRIES),
		.SHORT_CLEAR(SHORT_CLEAR),
		.LONG_CLEAR(LONG_CLEAR)
	) u_wait (
		.clock(clock),
		.reset(reset),
		.fetch_index(virtual_program_counter[`PC_INDEX_LSB +: WI]),
		.fetch_wait_bit(store_wait_bit),
		.set_valid(wait_set),
		.set_index(replay_pc[`PC_INDEX_LSB +: WI]),
		.long_clear_interval_select(long_clear_interval_select)
	);
	// The issue queue uses store_wait_bit to hold marked loads behind older stores
endmodule

/* memory_order_chk.sv */
// Port-level concurrent checks for the memory ordering and replay block
`timescale 1ns/1ps
module memory_order_chk
	import memory_order_pkg::*;
#(
	parameter int AGE_WIDTH = 7
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic full_memory_barrier,
	input wire logic write_memory_barrier,
	input wire logic hold_load_issue,
	input wire logic hold_store_issue,
	input wire logic load_issue_valid,
	input wire logic [AGE_WIDTH-1:0] load_issue_age,
	input wire logic store_issue_valid,
	input wire logic miss_valid,
	input wire logic [AGE_WIDTH-1:0] miss_age,
	input wire logic miss_merged,
	input wire logic miss_allocated,
	input wire logic replay_valid,
	input wire memory_order_pkg::trap_kind_type replay_kind,
	input wire logic [AGE_WIDTH-1:0] replay_age
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////
	// A trap of one kind shown on the replay port
	sequence s_trap(trap_kind_type k);
		replay_valid && replay_kind == k;
	endsequence
	property p_hold_load;
		hold_load_issue == full_memory_barrier;
	endproperty
	property p_hold_store;
		hold_store_issue == (full_memory_barrier || write_memory_barrier);
	endproperty
	property p_one_answer;
		!(miss_merged && miss_allocated);
	endproperty
	property p_answer_cause;
		(miss_merged || miss_allocated) |-> $past(miss_valid);
	endproperty
	property p_kind_set;
		replay_valid |-> replay_kind != trap_none;
	endproperty
	// A full trap lands on the incoming load, or on the incoming miss when no entry is free
	property p_full_target;
		s_trap(trap_queue_full) |-> ($past(load_issue_valid) && replay_age == $past(load_issue_age))
			|| ($past(miss_valid) && replay_age == $past(miss_age));
	endproperty
	property p_conflict_target;
		s_trap(trap_line_conflict) |-> $past(miss_valid) && replay_age == $past(miss_age);
	endproperty
	property p_ll_cause;
		s_trap(trap_load_load) |-> $past(load_issue_valid) && replay_age != $past(load_issue_age);
	endproperty
	property p_sl_cause;
		s_trap(trap_store_load) |-> $past(store_issue_valid);
	endproperty
	////////////////////////////////////////////////////////////
	a_hold_load: assert property (p_hold_load) else $error("load hold differs from barrier");
	a_hold_store: assert property (p_hold_store) else $error("store hold differs from barriers");
	a_one_answer: assert property (p_one_answer) else $error("miss both merged and allocated");
	a_answer_cause: assert property (p_answer_cause) else $error("miss answer without miss");
	a_kind_set: assert property (p_kind_set) else $error("replay without kind");
	a_full_target: assert property (p_full_target) else $error("queue full trap target wrong");
	a_conflict_target: assert property (p_conflict_target) else $error("line trap target wrong");
	a_ll_cause: assert property (p_ll_cause) else $error("load order trap cause wrong");
	a_sl_cause: assert property (p_sl_cause) else $error("store order trap without store");
endmodule
bind memory_order_replay_control memory_order_chk #(.AGE_WIDTH(AGE_WIDTH)) chk_u (.clock, .reset,
	.full_memory_barrier, .write_memory_barrier, .hold_load_issue, .hold_store_issue, .load_issue_valid,
	.load_issue_age, .store_issue_valid, .miss_valid, .miss_age, .miss_merged, .miss_allocated,
	.replay_valid, .replay_kind, .replay_age);

/* issue_gate_model.sv */
// Issue queue model that keeps marked loads behind older unissued stores
`timescale 1ns/1ps
module issue_gate_model (
	input wire logic load_ready,
	input wire logic load_marked,
	input wire logic older_store_waiting,
	output logic load_go
);
	// A marked load goes only once no older store waits
	assign load_go = load_ready && (!load_marked || !older_store_waiting);
endmodule

/* memory_order_replay_control_tb.sv */
// Self-checking bench for the memory ordering and replay block
`timescale 1ns/1ps
`include "memory_order_consts.svh"
module memory_order_replay_control_tb;
	import memory_order_pkg::*;
	logic clock;
	logic reset = 1, full_memory_barrier = 0, write_memory_barrier = 0, hold_load_issue, hold_store_issue;
	logic load_issue_valid = 0, store_issue_valid = 0, retire_valid = 0, miss_valid = 0, fill_valid = 0;
	logic [43:0] load_issue_addr = '0, store_issue_addr = '0, miss_addr = '0;
	logic [7:0] load_issue_mask = '0, store_issue_mask = '0;
	logic [6:0] load_issue_age = '0, store_issue_age = '0, retire_age = '0, miss_age = '0, replay_age;
	logic [47:0] load_issue_pc = '0, store_issue_pc = '0, miss_pc = '0, virtual_program_counter = '0, replay_pc;
	miss_kind_type miss_kind = load_op;
	trap_kind_type replay_kind;
	logic [2:0] fill_entry = '0, miss_entry;
	logic miss_merged, miss_allocated, replay_valid, long_clear_interval_select = 0, store_wait_bit;
	logic older_store_waiting = 0, load_go;
	int mismatches = 0, check_count = 0;
	memory_order_replay_control #(.SHORT_CLEAR(16), .LONG_CLEAR(64)) dut_u (.clock, .reset,
		.full_memory_barrier, .write_memory_barrier, .hold_load_issue, .hold_store_issue, .load_issue_valid,
		.load_issue_addr, .load_issue_mask, .load_issue_age, .load_issue_pc, .store_issue_valid,
		.store_issue_addr, .store_issue_mask, .store_issue_age, .store_issue_pc, .retire_valid, .retire_age,
		.miss_valid, .miss_kind, .miss_addr, .miss_age, .miss_pc, .fill_valid, .fill_entry, .miss_merged,
		.miss_allocated, .miss_entry, .replay_valid, .replay_kind, .replay_age, .replay_pc,
		.virtual_program_counter, .long_clear_interval_select, .store_wait_bit);
	issue_gate_model gate_u (.load_ready(1'b1), .load_marked(store_wait_bit), .older_store_waiting, .load_go);
	////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////
	// Shared drivers and comparison
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick();
		@(posedge clock);
		load_issue_valid <= 0;
		store_issue_valid <= 0;
		miss_valid <= 0;
		retire_valid <= 0;
		fill_valid <= 0;
		#1;
	endtask
	task automatic do_reset();
		@(posedge clock);
		reset <= 1;
		repeat (2) @(posedge clock);
		reset <= 0;
	endtask
	task automatic ld(input logic [43:0] a, input logic [7:0] m, input logic [6:0] g);
		@(posedge clock);
		load_issue_valid <= 1;
		load_issue_addr <= a;
		load_issue_mask <= m;
		load_issue_age <= g;
		load_issue_pc <= {4'h0, a};
		tick();
	endtask
	task automatic st(input logic [43:0] a, input logic [7:0] m, input logic [6:0] g);
		@(posedge clock);
		store_issue_valid <= 1;
		store_issue_addr <= a;
		store_issue_mask <= m;
		store_issue_age <= g;
		store_issue_pc <= {4'h1, a};
		tick();
	endtask
	task automatic ms(input miss_kind_type k, input logic [43:0] a, input logic [6:0] g, input logic mg);
		@(posedge clock);
		miss_valid <= 1;
		miss_kind <= k;
		miss_addr <= a;
		miss_age <= g;
		miss_pc <= {4'h2, a};
		tick();
		check("miss_merged", miss_merged, mg);
		check("miss_allocated", miss_allocated, !mg && !replay_valid);
	endtask
	task automatic exp_rep(input trap_kind_type k, input logic [6:0] g);
		check("replay_valid", replay_valid, k != trap_none);
		if (k != trap_none) begin
			check("replay_kind", replay_kind, k);
			check("replay_age", replay_age, g);
		end
	endtask
	// Store-load trap on a load at 0x100, then fetch its pc
	task automatic mark();
		do_reset();
		ld(44'h100, 8'hf0, 7'd5);
		exp_rep(trap_none, 0);
		st(44'h100, 8'h0f, 7'd3);
		exp_rep(trap_none, 0);
		st(44'h100, 8'h10, 7'd2);
		exp_rep(trap_store_load, 7'd5);
		check("replay_pc", replay_pc, 48'h100);
		@(posedge clock);
		virtual_program_counter <= 48'h100;
		@(posedge clock);
		#1;
	endtask
	////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_store_wait();
		mark();
		check("store_wait_bit", store_wait_bit, 1);
		@(posedge clock);
		older_store_waiting <= 1;
		#1;
		check("load_go", load_go, 0);
		@(posedge clock);
		older_store_waiting <= 0;
		virtual_program_counter <= 48'h200;
		@(posedge clock);
		#1;
		check("load_go", load_go, 1);
		check("store_wait_bit", store_wait_bit, 0);
		$display("done store_wait");
	endtask
	task automatic t_load_order();
		do_reset();
		ld(44'h200, 8'hff, 7'd6);
		ld(44'h300, 8'hff, 7'd1);
		exp_rep(trap_none, 0);
		ld(44'h200, 8'h01, 7'd2);
		exp_rep(trap_load_load, 7'd6);
		ld(44'h80000000400, 8'hff, 7'd9);
		ld(44'h80000000800, 8'hff, 7'd8);
		exp_rep(trap_load_load, 7'd9);
		$display("done load_order");
	endtask
	task automatic t_queue_full();
		do_reset();
		for (int i = 1; i <= 8; i++) begin
			ld(44'(i * 8), 8'hff, 7'(i));
			exp_rep(trap_none, 0);
		end
		ld(44'h200, 8'hff, 7'd9);
		exp_rep(trap_queue_full, 7'd9);
		@(posedge clock);
		retire_valid <= 1;
		retire_age <= 7'd1;
		tick();
		ld(44'h200, 8'hff, 7'd10);
		exp_rep(trap_none, 0);
		$display("done queue_full");
	endtask
	task automatic t_miss();
		do_reset();
		ms(load_op, 44'h1000, 7'd1, 0);
		check("miss_entry", miss_entry, 3'h0);
		ms(store_op, 44'h1008, 7'd2, 0);
		check("miss_entry", miss_entry, 3'h1);
		ms(load_op, 44'h1010, 7'd3, 1);
		ms(load_op, 44'h1040, 7'd4, 0);
		check("miss_entry", miss_entry, 3'h2);
		ms(load_op, 44'h9000, 7'd5, 0);
		exp_rep(trap_line_conflict, 7'd5);
		for (int k = 2; k <= 5; k++) begin
			ms(miss_kind_type'(k), 44'h2000 + 44'(k * 64), 7'd6, 0);
			ms(miss_kind_type'(k), 44'h2008 + 44'(k * 64), 7'd7, 1);
		end
		// Fill frees entry 2, so a miss on its cache line no longer clashes
		@(posedge clock);
		fill_valid <= 1;
		fill_entry <= 3'h2;
		tick();
		ms(load_op, 44'h9040, 7'd8, 0);
		exp_rep(trap_none, 0);
		check("miss_entry", miss_entry, 3'h2);
		$display("done miss");
	endtask
	task automatic t_clear();
		@(posedge clock);
		long_clear_interval_select <= 1;
		mark();
		repeat (24) @(posedge clock);
		#1;
		check("store_wait_bit", store_wait_bit, 1);
		repeat (50) @(posedge clock);
		#1;
		check("store_wait_bit", store_wait_bit, 0);
		@(posedge clock);
		long_clear_interval_select <= 0;
		mark();
		repeat (20) @(posedge clock);
		#1;
		check("store_wait_bit", store_wait_bit, 0);
		$display("done clear");
	endtask
	task automatic t_barrier();
		@(posedge clock);
		full_memory_barrier <= 1;
		#1;
		check("hold_load_issue", hold_load_issue, 1);
		check("hold_store_issue", hold_store_issue, 1);
		@(posedge clock);
		full_memory_barrier <= 0;
		write_memory_barrier <= 1;
		#1;
		check("hold_load_issue", hold_load_issue, 0);
		check("hold_store_issue", hold_store_issue, 1);
		@(posedge clock);
		write_memory_barrier <= 0;
		$display("done barrier");
	endtask
	////////////////////////////////////////////////////////////
	// Verdict and main sequence
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		reset <= 0;
		t_store_wait();
		t_load_order();
		t_queue_full();
		t_miss();
		t_clear();
		t_barrier();
		end_of_test();
	end
endmodule
